//--- logic/flash_readout_protect_boot.sv
// readout protection level keeper, read gating, boot source and vector fetch
`timescale 1ns/1ns
module flash_readout_protect_boot #(
  parameter int SRAM_AW = 11
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic boot_strap_i,
  input wire rdp_pkg::level_e nv_level_i,
  input wire logic nv_valid_i,
  output logic nv_level_we_o,
  output rdp_pkg::level_e nv_level_o,
  input wire logic isp_set_req_i,
  input wire rdp_pkg::level_e isp_set_level_i,
  input wire logic swd_set_req_i,
  output logic set_done_o,
  output logic set_reject_o,
  input wire logic swd_rd_req_i,
  input wire logic isp_rd_req_i,
  input wire logic [31:0] flash_rdata_i,
  output logic rd_grant_o,
  output logic rd_refused_o,
  output logic [31:0] rd_data_o,
  output logic mass_erase_o,
  input wire logic mass_erase_done_i,
  input wire logic sw_wr_protect_i,
  input wire logic prog_req_i,
  output logic prog_allow_o,
  output rdp_pkg::boot_src_e boot_src_o,
  output logic loader_uart_en_o,
  output logic vec_fetch_o,
  output logic [31:0] vec_addr_o,
  input wire logic [31:0] vec_data_i,
  output logic [31:0] init_sp_o,
  output logic [31:0] init_pc_o,
  output logic core_run_o,
  input wire logic sram_req_i,
  input wire logic sram_we_i,
  input wire logic [SRAM_AW-1:0] sram_addr_i,
  input wire logic [31:0] sram_wdata_i,
  output logic [31:0] sram_rdata_o,
  output logic sram_ack_o,
  output logic parity_exc_o
);
  import rdp_pkg::*;
  // address width bounded so the parity array stays a sane size
  if (SRAM_AW < 1 || SRAM_AW > 16) begin : g_aw_chk
    $error("SRAM_AW out of range");
  end
  typedef enum logic [2:0] {
    st_load, st_strap, st_fetch_sp, st_fetch_pc, st_run, st_erase
  } state_e;
  state_e state_reg, state_next;
  level_e level_reg, level_next;
  boot_src_e src_reg, src_next;
  logic [31:0] sp_reg, sp_next, pc_reg, pc_next;
  logic done_reg, done_next, rej_reg, rej_next;
  logic grant_reg, grant_next, refused_reg, refused_next;
  logic [31:0] rdata_reg, rdata_next;
  logic lower_ok;

  // lowering permitted only from a/b, path-dependent
  always_comb begin
    lower_ok = 1'b0;
    case (level_reg)
      guarded_level_a: lower_ok = isp_set_req_i || swd_set_req_i;
      guarded_level_b: lower_ok = isp_set_req_i;
      locked_level: lower_ok = 1'b0;
      default: lower_ok = 1'b0;
    endcase
  end

  always_comb begin
    state_next = state_reg;
    level_next = level_reg;
    src_next = src_reg;
    sp_next = sp_reg;
    pc_next = pc_reg;
    done_next = 1'b0;
    rej_next = 1'b0;
    case (state_reg)
      st_load: if (nv_valid_i) begin
        level_next = nv_level_i;
        state_next = st_strap;
      end
      st_strap: begin
        // strap caught by a clocked step after release, never by reset
        src_next = (boot_strap_i == BOOT_LOADER) ? src_loader_rom : src_main_flash;
        state_next = st_fetch_sp;
      end
      st_fetch_sp: begin
        sp_next = vec_data_i;
        state_next = st_fetch_pc;
      end
      st_fetch_pc: begin
        pc_next = vec_data_i;
        state_next = st_run;
      end
      st_run: begin
        if (isp_set_req_i && isp_set_level_i != open_read_level) begin
          // raising only; the host command picks one of the three levels above open
          if (isp_set_level_i > level_reg) begin
            level_next = isp_set_level_i;
            done_next = 1'b1;
          end else begin
            rej_next = 1'b1;
          end
        end else if (isp_set_req_i || swd_set_req_i) begin
          if (level_reg == open_read_level) begin
            done_next = 1'b1;
          end else if (lower_ok) begin
            state_next = st_erase;
          end else begin
            rej_next = 1'b1;
          end
        end
      end
      st_erase: if (mass_erase_done_i) begin
        // level stays guarded until the array is blank
        level_next = open_read_level;
        done_next = 1'b1;
        state_next = st_run;
      end
      default: state_next = st_load;
    endcase
  end

  // read gating, one cycle answer
  always_comb begin
    grant_next = 1'b0;
    refused_next = 1'b0;
    rdata_next = rdata_reg;
    if (swd_rd_req_i || isp_rd_req_i) begin
      if (state_reg == st_run && level_reg == open_read_level) begin
        grant_next = 1'b1;
        rdata_next = flash_rdata_i;
      end else begin
        refused_next = 1'b1;
        rdata_next = ERASED_WORD;
      end
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= st_load;
      level_reg <= locked_level;
      src_reg <= src_main_flash;
      sp_reg <= '0;
      pc_reg <= '0;
      done_reg <= 1'b0;
      rej_reg <= 1'b0;
      grant_reg <= 1'b0;
      refused_reg <= 1'b0;
      rdata_reg <= '0;
    end else begin
      state_reg <= state_next;
      level_reg <= level_next;
      src_reg <= src_next;
      sp_reg <= sp_next;
      pc_reg <= pc_next;
      done_reg <= done_next;
      rej_reg <= rej_next;
      grant_reg <= grant_next;
      refused_reg <= refused_next;
      rdata_reg <= rdata_next;
    end
  end

  assign nv_level_we_o = done_reg;
  assign nv_level_o = level_reg;
  assign set_done_o = done_reg;
  assign set_reject_o = rej_reg;
  assign rd_grant_o = grant_reg;
  assign rd_refused_o = refused_reg;
  assign rd_data_o = rdata_reg;
  assign mass_erase_o = (state_reg == st_erase);
  assign prog_allow_o = prog_req_i && !sw_wr_protect_i && state_reg == st_run;
  assign boot_src_o = src_reg;
  assign loader_uart_en_o = (src_reg == src_loader_rom) && state_reg != st_load;
  assign vec_fetch_o = (state_reg == st_fetch_sp) || (state_reg == st_fetch_pc);
  assign vec_addr_o = (state_reg == st_fetch_pc) ? PC_VECTOR_ADDR : SP_VECTOR_ADDR;
  assign init_sp_o = sp_reg;
  assign init_pc_o = pc_reg;
  assign core_run_o = (state_reg == st_run) || (state_reg == st_erase);

  sram_parity_if #(.AW(SRAM_AW)) sram_bus ();
  assign sram_bus.req = sram_req_i;
  assign sram_bus.we = sram_we_i;
  assign sram_bus.addr = sram_addr_i;
  assign sram_bus.wdata = sram_wdata_i;
  assign sram_rdata_o = sram_bus.rdata;
  assign sram_ack_o = sram_bus.ack;
  assign parity_exc_o = sram_bus.parity_err;
  sram_parity #(.AW(SRAM_AW)) u_sram (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .bus(sram_bus)
  );

  sequence s_lower_req;
    state_reg == st_run && lower_ok && !(isp_set_req_i && isp_set_level_i != open_read_level);
  endsequence
  a_read_open_grant: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (swd_rd_req_i && state_reg == st_run && level_reg == open_read_level) |=> rd_grant_o)
    else $error("open read not granted");
  a_read_guard_refuse: assert property (@(posedge core_clk_i) disable iff (rst_i)
    ((swd_rd_req_i || isp_rd_req_i) && level_reg != open_read_level) |=> rd_refused_o && !rd_grant_o)
    else $error("guarded read not refused");
  a_lower_starts_erase: assert property (@(posedge core_clk_i) disable iff (rst_i)
    s_lower_req |=> mass_erase_o && level_reg != open_read_level)
    else $error("lowering without erase");
  a_level_b_swd: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (state_reg == st_run && level_reg == guarded_level_b && swd_set_req_i && !isp_set_req_i)
    |=> set_reject_o && !mass_erase_o) else $error("swd lowered level b");
  a_level_a_swd: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (state_reg == st_run && level_reg == guarded_level_a && swd_set_req_i && !isp_set_req_i)
    |=> mass_erase_o) else $error("swd refused at level a");
  a_locked_stays: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (level_reg == locked_level && state_reg != st_load) |=> level_reg == locked_level)
    else $error("locked level lowered");
  sequence s_vector_walk;
    vec_fetch_o && vec_addr_o == SP_VECTOR_ADDR
    ##1 vec_fetch_o && vec_addr_o == PC_VECTOR_ADDR
    ##1 core_run_o;
  endsequence
  a_boot_vectors: assert property (@(posedge core_clk_i) disable iff (rst_i)
    state_reg == st_fetch_sp |-> s_vector_walk) else $error("vector fetch order");
  a_strap_source: assert property (@(posedge core_clk_i) disable iff (rst_i)
    state_reg == st_strap |=> boot_src_o == (boot_strap_i ? src_loader_rom : src_main_flash)
    [*2]) else $error("boot source wrong");
  a_wr_protect: assert property (@(posedge core_clk_i) disable iff (rst_i)
    sw_wr_protect_i |-> !prog_allow_o) else $error("program while protected");
endmodule : flash_readout_protect_boot

//--- logic/rdp_pkg.sv
// constants, types and rule summary for the flash readout protection and boot block
// Function
// - open level lets debug port and serial loader read flash.
// - any higher level refuses flash reads from debug port and serial loader.
// - from guarded level a, either path may lower to open level.
// - from guarded level b, only the serial loader path may lower to open.
// - every lowering erases the whole flash array before reads reopen.
// - at locked level every lowering attempt is rejected.
// - four levels, set by a command from the serial programming host.
// - erase and write protection come from a separate software control bit; here it gates prog_allow_o only, mass_erase_o ignores it.
// - strap low at start-up boots main flash user program.
// - strap high boots the loader; programming via the first serial port.
// - core loads stack pointer from address 0, start vector from address 4.
// - a separate factory loader region sits beside the main flash.
// - sram has zero wait states, checks parity, raises exception on error.
package rdp_pkg;
  typedef enum logic [1:0] {
    open_read_level,
    guarded_level_a,
    guarded_level_b,
    locked_level
  } level_e;
  typedef enum logic [1:0] {
    src_main_flash,
    src_loader_rom
  } boot_src_e;
  localparam logic [31:0] SP_VECTOR_ADDR = 32'h0000_0000;
  localparam logic [31:0] PC_VECTOR_ADDR = 32'h0000_0004;
  localparam int LOADER_BYTES = 2048;
  localparam int MAIN_FLASH_BYTES = 65536;
  localparam logic BOOT_MAIN = 1'b0;
  localparam logic BOOT_LOADER = 1'b1;
  localparam logic [31:0] ERASED_WORD = 32'hffff_ffff;
endpackage : rdp_pkg

//--- logic/sram_parity.sv
// sram with byte parity, answers in the cycle after the request
`timescale 1ns/1ns
module sram_parity #(
  parameter int AW = 11
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  sram_parity_if.mem bus
);
  import rdp_pkg::*;
  if (AW < 1 || AW > 16) begin : g_aw_chk
    $error("AW out of range");
  end
  logic [31:0] mem_q [0:(1<<AW)-1];
  logic [3:0] par_q [0:(1<<AW)-1];
  logic [31:0] rdata_reg, rdata_next;
  logic ack_reg, ack_next;
  logic err_reg, err_next;
  logic [3:0] par_wr;
  // one parity bit per byte lane
  for (genvar g = 0; g < 4; g++) begin : g_par
    assign par_wr[g] = ^bus.wdata[8*g +: 8];
  end
  always_comb begin
    rdata_next = rdata_reg;
    err_next = 1'b0;
    ack_next = bus.req;
    if (bus.req && !bus.we) begin
      rdata_next = mem_q[bus.addr];
      for (int i = 0; i < 4; i++) begin
        if ((^mem_q[bus.addr][8*i +: 8]) != par_q[bus.addr][i]) begin
          err_next = 1'b1;
        end
      end
    end
  end
  // array kept out of reset so it maps to ram
  always_ff @(posedge core_clk_i) begin
    if (bus.req && bus.we) begin
      mem_q[bus.addr] <= bus.wdata;
      par_q[bus.addr] <= par_wr;
    end
  end
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_reg <= '0;
      ack_reg <= 1'b0;
      err_reg <= 1'b0;
    end else begin
      rdata_reg <= rdata_next;
      ack_reg <= ack_next;
      err_reg <= err_next;
    end
  end
  assign bus.rdata = rdata_reg;
  assign bus.ack = ack_reg;
  assign bus.parity_err = err_reg;
  a_sram_zero_wait: assert property (@(posedge core_clk_i) disable iff (rst_i)
    bus.req |=> bus.ack) else $error("sram ack not next cycle");
endmodule : sram_parity

//--- logic/sram_parity_if.sv
// sram port bundle between the protection top and the parity sram
`timescale 1ns/1ns
interface sram_parity_if #(parameter int AW = 11);
  logic req;
  logic we;
  logic [AW-1:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic ack;
  logic parity_err;
  modport ctrl (output req, output we, output addr, output wdata,
                input rdata, input ack, input parity_err);
  modport mem (input req, input we, input addr, input wdata,
               output rdata, output ack, output parity_err);
endinterface : sram_parity_if

//--- verif/rdp_partner.sv
// far side model: nonvolatile level store, erase engine, vector memory
`timescale 1ns/1ns
module rdp_partner
  import rdp_pkg::*;
#(
  parameter logic [31:0] SP_WORD = 32'h2000_0000,
  parameter logic [31:0] PC_WORD = 32'h0000_0101
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic nv_we_i,
  input wire rdp_pkg::level_e nv_wr_i,
  output rdp_pkg::level_e nv_level_o,
  output logic nv_valid_o,
  input wire logic erase_i,
  input wire logic [2:0] lag_i,
  output logic erase_done_o,
  input wire logic vec_fetch_i,
  input wire logic [31:0] vec_addr_i,
  output logic [31:0] vec_data_o
);
  level_e store_reg = open_read_level;
  logic [2:0] wait_reg;
  logic [31:0] junk_reg;
  // no reset here: the level must outlive every reset
  always @(posedge core_clk_i) begin
    if (nv_we_i) store_reg <= nv_wr_i;
  end
  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      nv_valid_o <= 1'b0;
      wait_reg <= 3'h0;
      erase_done_o <= 1'b0;
      junk_reg <= 32'h5a5a_a5a5;
    end else begin
      nv_valid_o <= 1'b1;
      junk_reg <= ~junk_reg + 32'h1;
      wait_reg <= !erase_i ? 3'h0 : (wait_reg == lag_i ? wait_reg : wait_reg + 3'h1);
      erase_done_o <= erase_i && !erase_done_o && wait_reg == lag_i;
    end
  end
  // idle lines toggle so a stale value never looks valid
  assign nv_level_o = nv_valid_o ? store_reg : level_e'(junk_reg[1:0]);
  assign vec_data_o = !vec_fetch_i ? junk_reg :
    vec_addr_i == SP_VECTOR_ADDR ? SP_WORD :
    vec_addr_i == PC_VECTOR_ADDR ? PC_WORD : ~junk_reg;
endmodule : rdp_partner

//--- verif/tb.sv
// self-checking bench for readout protection, boot and sram
`timescale 1ns/1ns
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin bad_count++; $display("BAD %s exp %0h got %0h", n, e, s); end end
module tb;
  import rdp_pkg::*;
  logic core_clk_i = 0, rst_i = 1, boot_strap_i = 0, isp_set_req_i = 0, swd_set_req_i = 0;
  logic swd_rd_req_i = 0, isp_rd_req_i = 0, sw_wr_protect_i = 0, prog_req_i = 0;
  logic sram_req_i = 0, sram_we_i = 0, nv_valid_i, nv_level_we_o, mass_erase_done_i;
  logic [10:0] sram_addr_i = '0;
  logic [31:0] flash_rdata_i = '0, sram_wdata_i = '0, vec_data_i, rd_data_o, vec_addr_o;
  logic [31:0] init_sp_o, init_pc_o, sram_rdata_o;
  logic [2:0] lag = 3'h1;
  level_e nv_level_i, nv_level_o, isp_set_level_i = open_read_level, lv;
  boot_src_e boot_src_o;
  logic set_done_o, set_reject_o, rd_grant_o, rd_refused_o, mass_erase_o, prog_allow_o;
  logic loader_uart_en_o, vec_fetch_o, core_run_o, sram_ack_o, parity_exc_o;
  int bad_count = 0, cmp_count = 0;
  localparam logic [31:0] SP_W = 32'h2000_1ff0, PC_W = 32'h0000_0141;

  flash_readout_protect_boot dut (.core_clk_i, .rst_i, .boot_strap_i, .nv_level_i, .nv_valid_i,
    .nv_level_we_o, .nv_level_o, .isp_set_req_i, .isp_set_level_i, .swd_set_req_i, .set_done_o,
    .set_reject_o, .swd_rd_req_i, .isp_rd_req_i, .flash_rdata_i, .rd_grant_o, .rd_refused_o,
    .rd_data_o, .mass_erase_o, .mass_erase_done_i, .sw_wr_protect_i, .prog_req_i, .prog_allow_o,
    .boot_src_o, .loader_uart_en_o, .vec_fetch_o, .vec_addr_o, .vec_data_i, .init_sp_o,
    .init_pc_o, .core_run_o, .sram_req_i, .sram_we_i, .sram_addr_i, .sram_wdata_i, .sram_rdata_o,
    .sram_ack_o, .parity_exc_o);
  rdp_partner #(.SP_WORD(SP_W), .PC_WORD(PC_W)) far (.core_clk_i, .rst_i,
    .nv_we_i(nv_level_we_o), .nv_wr_i(nv_level_o), .nv_level_o(nv_level_i),
    .nv_valid_o(nv_valid_i), .erase_i(mass_erase_o), .lag_i(lag),
    .erase_done_o(mass_erase_done_i), .vec_fetch_i(vec_fetch_o), .vec_addr_i(vec_addr_o),
    .vec_data_o(vec_data_i));

  initial begin
    forever #5 core_clk_i = ~core_clk_i;
  end

  task automatic end_sim;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_sim

  task automatic boot(input logic s);
    int i;
    @(posedge core_clk_i);
    rst_i <= 1'b1;
    boot_strap_i <= s;
    repeat (8) @(posedge core_clk_i);
    rst_i <= 1'b0;
    for (i = 0; i < 30 && core_run_o !== 1'b1; i++) begin
      @(posedge core_clk_i);
      #1;
    end
    `CHK("core_run", 1'b1, core_run_o)
    `CHK("boot_src", s ? src_loader_rom : src_main_flash, boot_src_o)
    `CHK("uart_en", s, loader_uart_en_o)
    `CHK("init_sp", SP_W, init_sp_o)
    `CHK("init_pc", PC_W, init_pc_o)
    `CHK("level", lv, nv_level_o)
    $display("test boot strap=%0d done", s);
  endtask : boot

  task automatic rd(input bit swd);
    logic [31:0] d;
    d = $urandom;
    @(posedge core_clk_i);
    flash_rdata_i <= d;
    swd_rd_req_i <= swd;
    isp_rd_req_i <= !swd;
    @(posedge core_clk_i);
    swd_rd_req_i <= 1'b0;
    isp_rd_req_i <= 1'b0;
    flash_rdata_i <= ~d;
    #1;
    `CHK("rd_grant", lv == open_read_level, rd_grant_o)
    `CHK("rd_refused", lv != open_read_level, rd_refused_o)
    `CHK("rd_data", lv == open_read_level ? d : ERASED_WORD, rd_data_o)
  endtask : rd

  function automatic level_e nxt(bit isp, level_e req, level_e cur);
    if (isp && req > cur) return req;
    if (req != open_read_level || cur == locked_level) return cur;
    if (cur == guarded_level_b && !isp) return cur;
    return req;
  endfunction : nxt

  task automatic cmd(input bit isp, input level_e req);
    level_e n;
    bit seen;
    bit ok;
    int i;
    n = nxt(isp, req, lv);
    ok = n != lv || (isp && req == open_read_level && lv == open_read_level);
    seen = 0;
    lag = 3'($urandom_range(6, 0));
    @(posedge core_clk_i);
    isp_set_req_i <= isp;
    swd_set_req_i <= !isp;
    isp_set_level_i <= req;
    @(posedge core_clk_i);
    isp_set_req_i <= 1'b0;
    swd_set_req_i <= 1'b0;
    #1;
    for (i = 0; i < 40 && set_done_o !== 1'b1 && set_reject_o !== 1'b1; i++) begin
      seen |= mass_erase_o;
      @(posedge core_clk_i);
      #1;
    end
    `CHK("set_done", ok, set_done_o)
    `CHK("set_reject", !ok, set_reject_o)
    `CHK("erase", n < lv, seen)
    `CHK("level", n, nv_level_o)
    lv = n;
    $display("test cmd isp=%0d level=%0d done", isp, req);
  endtask : cmd

  task automatic sram(input bit we, input logic [10:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    sram_req_i <= 1'b1;
    sram_we_i <= we;
    sram_addr_i <= a;
    sram_wdata_i <= d;
    @(posedge core_clk_i);
    sram_req_i <= 1'b0;
    sram_wdata_i <= ~d;
    #1;
    `CHK("sram_ack", 1'b1, sram_ack_o)
    `CHK("parity_exc", 1'b0, parity_exc_o)
    if (!we) `CHK("sram_rdata", d, sram_rdata_o)
  endtask : sram

  initial begin
    int i;
    logic [31:0] w;
    static bit isps[10] = '{1, 1, 0, 1, 0, 1, 1, 1, 1, 0};
    static level_e lvls[10] = '{guarded_level_a, guarded_level_a, open_read_level, guarded_level_b,
      open_read_level, guarded_level_a, open_read_level, locked_level, open_read_level,
      open_read_level};
    void'($urandom(32'h75ca));
    lv = open_read_level;
    boot(1'b0);
    for (i = 0; i < 4; i++) rd(i[0]);
    for (i = 0; i < 6; i++) begin
      w = $urandom;
      sram(1'b1, i == 0 ? 11'h7ff : w[10:0], w);
      sram(1'b0, i == 0 ? 11'h7ff : w[10:0], w);
    end
    for (i = 0; i < 6; i++) begin
      w = $urandom;
      @(posedge core_clk_i);
      sw_wr_protect_i <= w[0];
      prog_req_i <= w[1];
      #1;
      `CHK("prog_allow", w[1] & !w[0], prog_allow_o)
    end
    $display("test sram and program gate done");
    for (i = 0; i < 10; i++) begin
      cmd(isps[i], lvls[i]);
      rd(1'b0);
      rd(1'b1);
    end
    boot(1'b1);
    rd(1'b1);
    cmd(1'b1, open_read_level);
    end_sim;
  end

  initial begin
    #200000;
    bad_count++;
    end_sim;
  end
endmodule : tb
